// *** usb_traffic_lamp_blinker.sv ***
// traffic indicator lamp controller with apb registers
//
// What this block does
// (R1) enabled and not overridden, the lamp shows bulk-out receive traffic
// (R2) enable clear keeps the lamp off whatever else happens
// (R3) enable and override set: software level drives lamp, traffic ignored
// (R4) every bulk-out packet counts, data-stage bytes only
// (R5) while enabled and steady/fast/slow, rate is compared periodically
// (R6) fast threshold checked first; above it, flash at fast blink time
// (R7) else above slow threshold, flash at slow blink time
// (R8) steady state entered on first enable and on leaving suspend
// (R9) fast or slow falls back to steady when its threshold is not exceeded
// (R10) threshold change or blink time write forces steady state
// (R11) entering steady state restarts rate measurement
// (R12) all-ones threshold disables that comparison
// (R13) both thresholds disabled: lamp stays steady and lit
// (R14) both thresholds reset to all ones
// (R15) software keeps enable clear while audio clock uses alternate pin 1
// (R16) software accesses registers only once the system clock runs
// (R17) while suspended, measurement paused and lamp off unless override set; resume to steady
// (R18) fast and slow states toggle the lamp once per blink time in cycles
module usb_traffic_lamp_blinker #(
	parameter int WINDOW_CYCLES = lamp_pkg::RATE_WINDOW_CYCLES
) (
	input  wire logic                         clock,
	input  wire logic                         resetn,
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [lamp_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]                  pwdata,
	input  wire logic [3:0]                   pstrb,
	output logic      [31:0]                  prdata,
	output logic                              pready,
	output logic                              pslverr,
	input  wire logic                         bulk_byte_strobe,
	input  wire logic                         usb_suspend,
	output logic                              lamp_out
);
	import lamp_pkg::*;

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		logic        enable;
		logic        sw_override;
		logic        sw_level;
		logic [15:0] fast_rate_threshold;
		logic [15:0] slow_rate_threshold;
		logic [15:0] fast_blink;
		logic [15:0] slow_blink;
		lamp_state_t state;
		logic [15:0] blink_cnt;
		logic        lamp;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} blinker_state_t;

	blinker_state_t q;
	blinker_state_t d;
	logic           enter_steady;
	logic           force_steady;
	logic           fast_hit;
	logic           slow_hit;
	logic           access;
	logic           wr;
	logic [31:0]    ctrl_rd;
	logic [31:0]    thr_rd;
	logic [31:0]    blink_rd;
	logic [31:0]    thr_new;
	logic [31:0]    blink_new;
	logic [31:0]    ctrl_new;
	logic [15:0]    period;

	meter_if mif ();

	traffic_rate_meter #(
		.WINDOW_CYCLES(WINDOW_CYCLES)
	) u_meter (
		.clock  (clock),
		.resetn (resetn),
		.mif    (mif)
	);

	function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] strb);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		return (old_v & ~m) | (new_v & m);
	endfunction : merge

	// ************************************************************
	// register views
	// ************************************************************
	always_comb begin
		ctrl_rd = '0;
		ctrl_rd[ENABLE_BIT]   = q.enable;
		ctrl_rd[OVERRIDE_BIT] = q.sw_override;
		ctrl_rd[SW_LEVEL_BIT] = q.sw_level;
		ctrl_rd[STATE_LSB+:3] = q.state;
		ctrl_rd[LAMP_BIT]     = q.lamp;
		thr_rd   = '0;
		thr_rd[FAST_LSB+:FIELD_W]   = q.fast_rate_threshold;
		thr_rd[SLOW_LSB+:FIELD_W]   = q.slow_rate_threshold;
		blink_rd = '0;
		blink_rd[FAST_LSB+:FIELD_W] = q.fast_blink;
		blink_rd[SLOW_LSB+:FIELD_W] = q.slow_blink;
		thr_new   = merge(thr_rd, pwdata, pstrb);
		blink_new = merge(blink_rd, pwdata, pstrb);
		ctrl_new  = merge(ctrl_rd, pwdata, pstrb);
	end

	assign access = psel && penable && q.pready;
	assign wr     = access && pwrite && !q.pslverr;

	// all-ones threshold never counts as exceeded [R12]
	assign fast_hit = (q.fast_rate_threshold != THRESHOLD_OFF) && (mif.rate > q.fast_rate_threshold);
	assign slow_hit = (q.slow_rate_threshold != THRESHOLD_OFF) && (mif.rate > q.slow_rate_threshold);

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		d            = q;
		force_steady = 1'b0;
		enter_steady = 1'b0;
		period       = 16'h0000;
		d.pready     = 1'b0;
		d.pslverr    = 1'b0;

		// apb setup phase: answer registered for the access phase
		if (psel && !penable) begin
			d.pready = 1'b1;
			case (paddr)
				CONTROL_OFFSET:   d.prdata = ctrl_rd;
				THRESHOLD_OFFSET: d.prdata = thr_rd;
				BLINK_OFFSET:     d.prdata = blink_rd;
				default: begin
					d.prdata  = '0;
					d.pslverr = 1'b1;
				end
			endcase
		end

		if (wr) begin
			case (paddr)
				CONTROL_OFFSET: begin
					d.enable      = ctrl_new[ENABLE_BIT];
					d.sw_override = ctrl_new[OVERRIDE_BIT];
					d.sw_level    = ctrl_new[SW_LEVEL_BIT];
				end
				THRESHOLD_OFFSET: begin
					d.fast_rate_threshold = thr_new[FAST_LSB+:FIELD_W];
					d.slow_rate_threshold = thr_new[SLOW_LSB+:FIELD_W];
					if (thr_new != thr_rd)
						force_steady = 1'b1; // [R10]
				end
				BLINK_OFFSET: begin
					d.fast_blink = blink_new[FAST_LSB+:FIELD_W];
					d.slow_blink = blink_new[SLOW_LSB+:FIELD_W];
					force_steady = 1'b1; // [R10]
				end
				default: begin
				end
			endcase
		end

		if (!q.enable) begin
			// disabled lamp stays dark [R2]
			d.state     = LAMP_OFF;
			d.lamp      = 1'b0;
			d.blink_cnt = '0;
		end else if (q.sw_override) begin
			// software owns the lamp, traffic ignored [R3]
			d.state     = LAMP_OFF;
			d.lamp      = q.sw_level;
			d.blink_cnt = '0;
		end else if (usb_suspend) begin
			// dark and measurement paused while suspended [R17]
			d.state     = LAMP_SUSPEND;
			d.lamp      = 1'b0;
			d.blink_cnt = '0;
		end else begin
			// traffic indication [R1]
			case (q.state)
				LAMP_OFF, LAMP_SUSPEND: begin
					d.state = STEADY_LIT_STATE; // [R8]
				end
				STEADY_LIT_STATE: begin
					// fast checked before slow [R5] [R6] [R7]
					if (mif.sample && fast_hit)
						d.state = FAST_FLASH_STATE;
					else if (mif.sample && slow_hit)
						d.state = SLOW_FLASH_STATE;
				end
				FAST_FLASH_STATE: begin
					if (mif.sample && !fast_hit)
						d.state = STEADY_LIT_STATE; // [R9]
				end
				SLOW_FLASH_STATE: begin
					if (mif.sample && fast_hit)
						d.state = FAST_FLASH_STATE; // [R6]
					else if (mif.sample && !slow_hit)
						d.state = STEADY_LIT_STATE; // [R9]
				end
				default: begin
					d.state = STEADY_LIT_STATE;
				end
			endcase

			if (force_steady)
				d.state = STEADY_LIT_STATE; // [R10]

			// blink period per state, zero treated as one cycle [R6] [R7]
			period = (d.state == FAST_FLASH_STATE) ? q.fast_blink : q.slow_blink;
			if (period == 16'h0000)
				period = 16'h0001;

			if (d.state == STEADY_LIT_STATE) begin
				// continuously lit while no threshold trips [R13]
				d.lamp      = 1'b1;
				d.blink_cnt = '0;
			end else if (d.state != q.state) begin
				d.lamp      = 1'b1;
				d.blink_cnt = '0;
			end else if (q.blink_cnt >= period - 16'h0001) begin
				// one toggle per blink interval [R18]
				d.lamp      = ~q.lamp;
				d.blink_cnt = '0;
			end else begin
				d.blink_cnt = q.blink_cnt + 16'h0001;
			end

			// restart measurement on each steady entry [R11]
			enter_steady = (d.state == STEADY_LIT_STATE) &&
				((q.state != STEADY_LIT_STATE) || force_steady);
		end
	end

	// ************************************************************
	// rate meter hookup
	// ************************************************************
	assign mif.restart   = enter_steady;
	assign mif.byte_seen = bulk_byte_strobe; // [R4]
	assign mif.pause     = !((q.state == STEADY_LIT_STATE) || (q.state == FAST_FLASH_STATE) ||
		(q.state == SLOW_FLASH_STATE)) || !q.enable || q.sw_override || usb_suspend; // [R17]

	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			q            <= '0;
			q.state      <= LAMP_OFF;
			q.fast_rate_threshold   <= THRESHOLD_OFF; // [R14]
			q.slow_rate_threshold   <= THRESHOLD_OFF; // [R14]
			q.fast_blink <= FAST_BLINK_RESET;
			q.slow_blink <= SLOW_BLINK_RESET;
		end else begin
			q <= d;
		end
	end

	assign prdata   = q.prdata;
	assign pready   = q.pready;
	assign pslverr  = q.pslverr;
	assign lamp_out = q.lamp;

endmodule : usb_traffic_lamp_blinker

// *** lamp_pkg.sv ***
// constants and types shared by the traffic lamp blinker
package lamp_pkg;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLOCK_MHZ         = 100;
	localparam int RATE_WINDOW_US    = 1000;
	localparam int RATE_WINDOW_CYCLES = RATE_WINDOW_US * CLOCK_MHZ;

	// ************************************************************
	// apb register map
	// ************************************************************
	localparam int          ADDR_W           = 16;
	localparam logic [15:0] CONTROL_OFFSET   = 16'h8080;
	localparam logic [15:0] THRESHOLD_OFFSET = 16'h8084;
	localparam logic [15:0] BLINK_OFFSET     = 16'h8088;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int ENABLE_BIT    = 0;
	localparam int OVERRIDE_BIT  = 1;
	localparam int SW_LEVEL_BIT  = 2;
	localparam int STATE_LSB     = 4;
	localparam int LAMP_BIT      = 8;
	localparam int FAST_LSB      = 0;
	localparam int SLOW_LSB      = 16;
	localparam int FIELD_W       = 16;

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [15:0] THRESHOLD_OFF     = 16'hffff;
	localparam logic [15:0] FAST_BLINK_RESET  = 16'h1000;
	localparam logic [15:0] SLOW_BLINK_RESET  = 16'h4000;

	typedef enum logic [2:0] {
		LAMP_OFF,
		LAMP_SUSPEND,
		STEADY_LIT_STATE,
		FAST_FLASH_STATE,
		SLOW_FLASH_STATE
	} lamp_state_t;

endpackage : lamp_pkg

// *** meter_if.sv ***
// traffic meter handshake between the lamp controller and its rate meter
interface meter_if;
	logic        restart;
	logic        pause;
	logic        byte_seen;
	logic        sample;
	logic [15:0] rate;

	modport ctrl  (output restart, output pause, output byte_seen, input sample, input rate);
	modport meter (input restart, input pause, input byte_seen, output sample, output rate);
endinterface : meter_if

// *** traffic_rate_meter.sv ***
// counts bulk-out data bytes over a fixed window and reports the total
module traffic_rate_meter #(
	parameter int WINDOW_CYCLES = lamp_pkg::RATE_WINDOW_CYCLES
) (
	input  wire logic clock,
	input  wire logic resetn,
	meter_if.meter    mif
);
	import lamp_pkg::*;

	typedef struct packed {
		logic [31:0] win_cnt;
		logic [15:0] bytes;
		logic        sample;
		logic [15:0] rate;
	} meter_state_t;

	meter_state_t q;
	meter_state_t d;

	always_comb begin
		d = q;
		d.sample = 1'b0;
		if (mif.restart) begin
			// fresh window on every entry into steady state [R11]
			d.win_cnt = '0;
			d.bytes   = '0;
		end else if (!mif.pause) begin
			// data-stage bytes only, saturating [R4]
			if (mif.byte_seen && q.bytes != 16'hffff)
				d.bytes = q.bytes + 16'h0001;
			if (q.win_cnt == 32'(WINDOW_CYCLES - 1)) begin
				d.win_cnt = '0;
				d.sample  = 1'b1;
				d.rate    = d.bytes;
				d.bytes   = '0;
			end else begin
				d.win_cnt = q.win_cnt + 32'h0000_0001;
			end
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			q <= '0;
		else
			q <= d;
	end

	assign mif.sample = q.sample;
	assign mif.rate   = q.rate;

endmodule : traffic_rate_meter

// *** lamp_blinker_sva.sv ***
// assertion checker for the traffic lamp blinker
module lamp_blinker_sva #(
	parameter int WINDOW_CYCLES = 64
) (
	input wire logic                         clock,
	input wire logic                         resetn,
	input wire logic                         psel,
	input wire logic                         penable,
	input wire logic                         pwrite,
	input wire logic [lamp_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0]                  pwdata,
	input wire logic [3:0]                   pstrb,
	input wire logic [31:0]                  prdata,
	input wire logic                         pready,
	input wire logic                         pslverr,
	input wire logic                         bulk_byte_strobe,
	input wire logic                         usb_suspend,
	input wire logic                         lamp_out
);
	import lamp_pkg::*;
	logic [2:0] ctl_q;
	logic [3:0] age_q;
	logic       hit;
	assign hit = paddr == CONTROL_OFFSET || paddr == THRESHOLD_OFFSET || paddr == BLINK_OFFSET;
	// shadow of control bits and cycles since last control write
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ctl_q <= 3'h0;
			age_q <= 4'h0;
		end else if (psel && penable && pready && pwrite && paddr == CONTROL_OFFSET && pstrb[0]) begin
			ctl_q <= pwdata[2:0];
			age_q <= 4'h0;
		end else if (age_q != 4'hf) begin
			age_q <= age_q + 4'h1;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	property p_ready_next; psel && !penable |=> pready; endproperty
	property p_ready_pulse; pready |=> !pready; endproperty
	property p_ready_only; pready |-> psel && penable; endproperty
	property p_err_map; pready |-> pslverr == !hit; endproperty
	property p_err_data; pready && pslverr |-> prdata == 32'h0; endproperty
	property p_suspend_off; usb_suspend [*4] |-> !lamp_out; endproperty
	property p_disabled_off; age_q >= 4'h3 && !ctl_q[0] |-> !lamp_out; endproperty
	property p_override; age_q >= 4'h3 && ctl_q[1:0] == 2'b11 && !usb_suspend |-> lamp_out == ctl_q[2];
	endproperty
	a_ready_next: assert property (p_ready_next) else $error("no ready after setup");
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
	a_ready_only: assert property (p_ready_only) else $error("ready outside access");
	a_err_map: assert property (p_err_map) else $error("slave error mismatch");
	a_err_data: assert property (p_err_data) else $error("data on error");
	a_suspend_off: assert property (p_suspend_off) else $error("lamp lit in suspend");
	a_disabled_off: assert property (p_disabled_off) else $error("lamp lit when off");
	a_override: assert property (p_override) else $error("lamp ignores software");
	c_read: cover property (pready && !pwrite);
	c_unmapped: cover property (pready && pslverr);
	c_blink: cover property ($fell(lamp_out) && ctl_q == 3'h1);
endmodule : lamp_blinker_sva

bind usb_traffic_lamp_blinker lamp_blinker_sva #(.WINDOW_CYCLES(WINDOW_CYCLES)) u_sva (
	.clock(clock), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .bulk_byte_strobe(bulk_byte_strobe), .usb_suspend(usb_suspend),
	.lamp_out(lamp_out));

// *** lamp_model.sv ***
// indicator lamp: measures cycles between lamp toggles
module lamp_model (
	input wire logic clock,
	input wire logic lamp_out,
	output int       period
);
	timeunit 1ns;
	timeprecision 1ps;
	int   run_q = 0;
	logic last_q = 1'b0;
	always @(posedge clock) begin
		run_q <= run_q + 1;
		if (lamp_out !== last_q) begin
			period <= run_q;
			run_q <= 1;
		end
		last_q <= lamp_out;
	end
endmodule : lamp_model

// *** usb_traffic_lamp_blinker_tb.sv ***
// self-checking bench for the traffic lamp blinker
module usb_traffic_lamp_blinker_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import lamp_pkg::*;
	localparam int W = 64;
	logic        clock = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [15:0] paddr = 16'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0]  pstrb = 4'hf;
	logic        pready, pslverr, err, bulk_byte_strobe = 0, usb_suspend = 0, lamp_out;
	int          err_total = 0, samples_checked = 0, cycles = 0, gap = 0, period;

	usb_traffic_lamp_blinker #(.WINDOW_CYCLES(W)) DUT (.clock(clock), .resetn(resetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.bulk_byte_strobe(bulk_byte_strobe), .usb_suspend(usb_suspend), .lamp_out(lamp_out));
	lamp_model u_lamp (.clock(clock), .lamp_out(lamp_out), .period(period));

	always #5 clock = ~clock;
	// traffic source: one byte every gap cycles, plus run limit
	always @(posedge clock) begin
		cycles <= cycles + 1;
		bulk_byte_strobe <= gap != 0 && cycles % gap == 0;
		if (cycles == 20000) begin
			err_total++;
			finish_test();
		end
	end

	task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask : apb

	task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", n, exp, seen);
		end
	endtask : chk

	task automatic rdm(input logic [15:0] a, input logic [31:0] m, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk("register", rd & m, exp);
	endtask : rdm

	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : finish_test

	initial begin
		repeat (6) @(posedge clock);
		resetn <= 1'b1;
		@(posedge clock);
		rdm(CONTROL_OFFSET, 32'hffffffff, 32'h0);
		rdm(THRESHOLD_OFFSET, 32'hffffffff, 32'hffffffff);
		rdm(BLINK_OFFSET, 32'hffffffff, 32'h40001000);
		rdm(16'h808c, 32'hffffffff, 32'h0);
		chk("unmapped", {31'h0, err}, 32'h1);
		gap = 1;
		apb(1'b1, CONTROL_OFFSET, 32'h1);
		repeat (3 * W) @(posedge clock);
		rdm(CONTROL_OFFSET, 32'hffffffff, 32'h121);
		apb(1'b1, BLINK_OFFSET, 32'h00080004);
		apb(1'b1, THRESHOLD_OFFSET, 32'h0002000a);
		rdm(CONTROL_OFFSET, 32'h71, 32'h21);
		repeat (3 * W) @(posedge clock);
		rdm(CONTROL_OFFSET, 32'h71, 32'h31);
		chk("fast period", period, 32'h4);
		apb(1'b1, BLINK_OFFSET, 32'h00080004);
		rdm(CONTROL_OFFSET, 32'h71, 32'h21);
		gap = 12;
		repeat (4 * W) @(posedge clock);
		rdm(CONTROL_OFFSET, 32'h71, 32'h41);
		chk("slow period", period, 32'h8);
		gap = 0;
		repeat (3 * W) @(posedge clock);
		rdm(CONTROL_OFFSET, 32'h71, 32'h21);
		gap = 1;
		apb(1'b1, CONTROL_OFFSET, 32'h7);
		repeat (4) @(posedge clock);
		chk("override on", {31'h0, lamp_out}, 32'h1);
		apb(1'b1, CONTROL_OFFSET, 32'h3);
		repeat (3 * W) @(posedge clock);
		chk("override off", {31'h0, lamp_out}, 32'h0);
		apb(1'b1, CONTROL_OFFSET, 32'h1);
		usb_suspend <= 1'b1;
		repeat (10) @(posedge clock);
		chk("suspend lamp", {31'h0, lamp_out}, 32'h0);
		rdm(CONTROL_OFFSET, 32'h71, 32'h11);
		usb_suspend <= 1'b0;
		repeat (2) @(posedge clock);
		rdm(CONTROL_OFFSET, 32'h71, 32'h21);
		apb(1'b1, CONTROL_OFFSET, 32'h0);
		repeat (4) @(posedge clock);
		chk("disabled lamp", {31'h0, lamp_out}, 32'h0);
		finish_test();
	end
endmodule : usb_traffic_lamp_blinker_tb
